// File: common/dsrc_defines.svh
// Timing counts and field positions for the DRAM strobe and refresh controller.
// Assumes a 125 MHz controller clock (MCLK) and a bus with latched low address bits.
`ifndef DSRC_DEFINES_SVH
`define DSRC_DEFINES_SVH

// Controller clock period in picoseconds
`define DSRC_CLK_PS 8000
// Row-to-column strobe window, least and most, in ns
`define DSRC_RAS_CAS_MIN_NS 123
`define DSRC_RAS_CAS_MAX_NS 164
// Least row-to-column delay in clocks, rounded up
`define DSRC_CAS_TAP ((`DSRC_RAS_CAS_MIN_NS * 1000 + `DSRC_CLK_PS - 1) / `DSRC_CLK_PS)
// Write data settles this long after the write strobe edge, in ns
`define DSRC_WR_DATA_NS 40
// Settle delay in clocks, rounded up
`define DSRC_WR_SETTLE ((`DSRC_WR_DATA_NS * 1000 + `DSRC_CLK_PS - 1) / `DSRC_CLK_PS)
// Row strobe extension tap and clear tap (after column strobe)
`define DSRC_RAS_TAP (`DSRC_CAS_TAP + 2)
`define DSRC_CLR_TAP (`DSRC_CAS_TAP + 3)
// Timing chain length
`define DSRC_CHAIN_LEN (`DSRC_CAS_TAP + 4)
// Address field layout
`define DSRC_ADDR_W 16
`define DSRC_BANK_HI 15
`define DSRC_BANK_LO 14
`define DSRC_ROW_HI 13
`define DSRC_ROW_LO 7
`define DSRC_COL_HI 6
`define DSRC_COL_LO 0
`define DSRC_MUX_W 7
`define DSRC_BANKS 4

`endif

// File: common/dsrc_pkg.sv
// Types shared by the DRAM strobe and refresh controller.
// Assumes dsrc_defines.svh is available on the include path.
`include "dsrc_defines.svh"
package dsrc_pkg;
   // Cycle kinds, Gray coded along idle-read/write-refresh
   typedef enum logic [1:0] {
      DSRC_IDLE = 2'b00,
      DSRC_READ = 2'b01,
      DSRC_WRITE = 2'b11,
      DSRC_REFR = 2'b10
   } dsrc_kind_t;
   // Refresh scheme select
   typedef enum logic [1:0] {
      DSRC_RF_HOLD = 2'b00,
      DSRC_RF_FETCH = 2'b01,
      DSRC_RF_SOFT = 2'b11
   } dsrc_rfmode_t;
endpackage : dsrc_pkg

// File: hw/dsrc_timing_chain.sv
// Shift register timing chain fed by the cycle request.
// Assumes the request input is already in the MCLK domain.
`timescale 1ns/1ps
`default_nettype none
`include "dsrc_defines.svh"
module dsrc_timing_chain (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic req_i,
   output logic [`DSRC_CHAIN_LEN-1:0] taps_o
);
   import dsrc_pkg::*;
   logic [`DSRC_CHAIN_LEN-1:0] chain_q; // One stage per clock

   // Each stage copies the one before; stage 0 follows request
   genvar gi;
   generate
      for (gi = 0; gi < `DSRC_CHAIN_LEN; gi++) begin : g_stage
         always_ff @(posedge MCLK) begin
            if (!RST_B) begin
               chain_q[gi] <= 1'b0;
            end else if (gi == 0) begin
               chain_q[gi] <= req_i;
            end else begin
               chain_q[gi] <= chain_q[(gi == 0) ? 0 : gi - 1];
            end
         end
      end
   endgenerate

   assign taps_o = chain_q;
endmodule : dsrc_timing_chain
`default_nettype wire

// File: hw/dsrc_ctrl.sv
// DRAM strobe and refresh controller: cycle request, bank row strobes,
// column strobe, row/column address mux and refresh sources.
// Assumes bus pins are asynchronous to MCLK; the hold arbiter, refresh
// timer and interrupt priority live outside.
//
// Operation
// [R01] Row strobe to all banks or decoded bank
// [R02] Row strobe extended by chain tap OR
// [R03] Column strobe 123..164 ns after row strobe
// [R04] Column tap never moved one stage earlier
// [R05] Write request waits for write strobe low
// [R06] Inhibit input suppresses DRAM cycles
// [R07] Accesses finish with no wait states
// [R08] Address latch transparent, captures on strobe fall
// [R09] Hold mode: grant performs one row refresh
// [R10] Outside generator requests at least every 15us
// [R11] Optional refresh hidden in opcode fetch
// [R12] Refresh continues through reset and long holds
// [R13] Output port forces all selected row strobes
// [R14] Software does 128 consecutive dummy reads
// [R15] Timer loaded with 15A4H or 2454H
// [R16] Auto reload load values D5A4H, E454H
// [R17] Timer output on top priority interrupt
// [R18] Arbiter keeps DMA off during refresh
// [R19] Refresh may go via DMA request line
// [R20] Request from latch strobe, write strobe, refresh
// [R21] Row is high address, column low
// [R22] Request starts row strobe and timing chain
// [R23] Chain tap clears request after column strobe
`timescale 1ns/1ps
`default_nettype none
`include "dsrc_defines.svh"
module dsrc_ctrl (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic [7:0] AD,
   input wire logic [7:0] A_HI,
   input wire logic ALE,
   input wire logic BUS_STATUS_BIT_ONE,
   input wire logic BUS_STATUS_BIT_ZERO,
   input wire logic WR_B,
   input wire logic INHIBIT,
   input wire logic REFRESH_REQ,
   input wire logic BUS_GRANT,
   input wire dsrc_pkg::dsrc_rfmode_t RF_MODE,
   input wire logic [`DSRC_BANKS-1:0] SOFT_RAS_FORCE,
   output logic HOLD_REQ,
   output logic [`DSRC_BANKS-1:0] RAS_B,
   output logic CAS_B,
   output logic WE_B,
   output logic [`DSRC_MUX_W-1:0] MA,
   output logic BUSY
);
   import dsrc_pkg::*;

   // Two-stage synchronisers for all pin inputs except RST_B, RF_MODE and SOFT_RAS_FORCE
   logic [7:0] ad_s1_q, ad_s2_q;
   logic [7:0] ahi_s1_q, ahi_s2_q;
   logic [5:0] ctl_s1_q, ctl_s2_q; // ale,s1,s0,wr_b,inh,rfreq
   logic grant_s1_q, grant_s2_q;
   logic ale, st1, st0, wr_b, inh, rf_req, grant;

   // Synchroniser flops; second stage alone is read onward
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         ad_s1_q <= 8'h00;
         ad_s2_q <= 8'h00;
         ahi_s1_q <= 8'h00;
         ahi_s2_q <= 8'h00;
         ctl_s1_q <= 6'h04;
         ctl_s2_q <= 6'h04;
         grant_s1_q <= 1'b0;
         grant_s2_q <= 1'b0;
      end else begin
         ad_s1_q <= AD;
         ad_s2_q <= ad_s1_q;
         ahi_s1_q <= A_HI;
         ahi_s2_q <= ahi_s1_q;
         ctl_s1_q <= {ALE, BUS_STATUS_BIT_ONE, BUS_STATUS_BIT_ZERO, WR_B, INHIBIT, REFRESH_REQ};
         ctl_s2_q <= ctl_s1_q;
         grant_s1_q <= BUS_GRANT;
         grant_s2_q <= grant_s1_q;
      end
   end

   assign {ale, st1, st0, wr_b, inh, rf_req} = ctl_s2_q;
   assign grant = grant_s2_q;

   // Address latch: follows bus while strobe high, holds after fall
   logic [7:0] alo_q; // Latched low address byte
   logic [7:0] ahi_q; // Latched high address byte
   logic ale_d1_q; // Strobe delayed one clock, for edges
   logic [`DSRC_ADDR_W-1:0] addr;

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         alo_q <= 8'h00;
         ahi_q <= 8'h00;
         ale_d1_q <= 1'b0;
      end else begin
         ale_d1_q <= ale;
         if (ale) begin // Transparent phase [R08]
            alo_q <= ad_s2_q;
            ahi_q <= ahi_s2_q;
         end
      end
   end

   // While the strobe is high the live bus is used, so the mux
   // has the address before the row strobe [R08]
   assign addr = ale ? {ahi_s2_q, ad_s2_q} : {ahi_q, alo_q};

   // Cycle request sources
   logic ale_fall;
   logic wr_b_d1_q; // Write strobe one clock ago
   logic wr_fall;
   logic [2:0] wr_cnt_q; // Write data settle counter
   logic wr_pend_q; // Write waiting for data to settle
   logic rd_cycle;
   logic fetch_cycle;
   logic rf_pend_q; // Refresh owed, sticky until served
   logic rf_go;
   logic req_q; // Cycle request flip-flop
   dsrc_kind_t kind_q; // What the running cycle is
   logic [`DSRC_CHAIN_LEN-1:0] taps;

   assign ale_fall = ale_d1_q && !ale;
   assign wr_fall = wr_b_d1_q && !wr_b;
   // Status 1x on the strobe means a read or fetch [R20]
   assign rd_cycle = ale_fall && st1;
   assign fetch_cycle = ale_fall && st1 && st0;

   // Refresh launch: granted hold, or hidden behind an opcode fetch
   always_comb begin
      case (RF_MODE)
         // Level, not edge: a grant that lands while the chain is busy
         // still gets its refresh once the chain drains [R09]
         DSRC_RF_HOLD: rf_go = rf_pend_q && grant;
         DSRC_RF_FETCH: rf_go = rf_pend_q && fetch_cycle; // [R11]
         default: rf_go = 1'b0; // Software dummy reads refresh
      endcase
   end

   // Write strobe edge tracking and settle counter [R05]
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         wr_b_d1_q <= 1'b1;
         wr_cnt_q <= 3'h0;
         wr_pend_q <= 1'b0;
      end else begin
         wr_b_d1_q <= wr_b;
         if (wr_fall && !inh) begin // Only after strobe goes low [R05]
            wr_pend_q <= 1'b1;
            wr_cnt_q <= 3'(`DSRC_WR_SETTLE);
         end else if (wr_pend_q && wr_cnt_q != 3'h0) begin
            wr_cnt_q <= wr_cnt_q - 3'h1;
         end else if (wr_pend_q && req_q && kind_q == DSRC_WRITE) begin
            wr_pend_q <= 1'b0; // Dropped only once the write is taken
         end
      end
   end

   // Refresh owed: a new request sets, launch clears; set wins.
   // Not cleared by a processor reset pin, only by RST_B, so rows
   // stay refreshed across processor resets [R12]
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         rf_pend_q <= 1'b0;
      end else begin
         if (rf_req) begin
            rf_pend_q <= 1'b1;
         end else if (rf_go && !req_q && taps[`DSRC_CHAIN_LEN-1:1] == '0) begin
            rf_pend_q <= 1'b0; // Same terms as the launch, so none is lost
         end
      end
   end

   // Hold asked while refresh is owed in hold mode [R09]
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         HOLD_REQ <= 1'b0;
      end else begin
         HOLD_REQ <= (RF_MODE == DSRC_RF_HOLD) && rf_pend_q; // [R09]
      end
   end

   // Cycle request flip-flop: set by a source, cleared from a tap
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         req_q <= 1'b0;
         kind_q <= DSRC_IDLE;
      end else if (req_q) begin
         if (taps[`DSRC_CLR_TAP-1]) begin // Clear after column strobe [R23]
            req_q <= 1'b0;
         end
      end else if (taps[`DSRC_CHAIN_LEN-1:1] == '0) begin // Chain drained
         if (rf_go) begin // Refresh needs no inhibit check [R20]
            req_q <= 1'b1;
            kind_q <= DSRC_REFR;
         end else if (rd_cycle && !inh) begin // Inhibit blocks DRAM [R06]
            req_q <= 1'b1; // Read starts at strobe fall [R20]
            kind_q <= DSRC_READ;
         end else if (wr_pend_q && wr_cnt_q == 3'h0) begin
            req_q <= 1'b1; // Write after settle [R05]
            kind_q <= DSRC_WRITE;
         end else begin
            kind_q <= DSRC_IDLE;
         end
      end
   end

   // Timing chain started by the request [R22]
   dsrc_timing_chain u_chain (
      .MCLK(MCLK),
      .RST_B(RST_B),
      .req_i(req_q),
      .taps_o(taps)
   );

   // Strobe and mux generation
   logic ras_en;
   logic [1:0] bank;
   logic [`DSRC_BANKS-1:0] bank_dec;
   logic cas_on;

   // Row strobe held past request clear by the chain tap [R02]
   assign ras_en = req_q || taps[`DSRC_RAS_TAP]; // [R02]
   assign bank = addr[`DSRC_BANK_HI:`DSRC_BANK_LO];
   // Column strobe from fixed tap; earlier would cut write setup [R03] [R04]
   assign cas_on = req_q && taps[`DSRC_CAS_TAP-1] || taps[`DSRC_CAS_TAP] && taps[`DSRC_RAS_TAP];

   // One-hot bank decode, one term per bank
   genvar bi;
   generate
      for (bi = 0; bi < `DSRC_BANKS; bi++) begin : g_bank
         assign bank_dec[bi] = (bank == 2'(bi)); // [R01]
      end
   endgenerate

   // Row strobes: all banks on refresh, else the decoded bank together
   // with any forced banks. Taken from flops, so the
   // strobe lags the request by one clock [R01] [R13] [R22]
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         RAS_B <= {`DSRC_BANKS{1'b1}};
      end else if (!ras_en) begin
         RAS_B <= {`DSRC_BANKS{1'b1}};
      end else if (kind_q == DSRC_REFR) begin
         RAS_B <= {`DSRC_BANKS{1'b0}}; // [R01]
      end else begin
         RAS_B <= ~(bank_dec | SOFT_RAS_FORCE); // [R01] [R13]
      end
   end

   // Column strobe; refresh is row only so it stays high
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         CAS_B <= 1'b1;
      end else begin
         CAS_B <= !(cas_on && kind_q != DSRC_REFR); // [R03]
      end
   end

   // Write enable spans the write cycle, ahead of column strobe
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         WE_B <= 1'b1;
      end else begin
         WE_B <= !(ras_en && kind_q == DSRC_WRITE);
      end
   end

   // Row address until the tap before the column tap, then column; the row is the high
   // bits. Refresh row comes from a counter advanced per refresh [R21]
   logic [`DSRC_MUX_W-1:0] rf_row_q; // Next row to refresh

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         rf_row_q <= 7'h00;
      end else if (kind_q == DSRC_REFR && req_q && taps[`DSRC_CLR_TAP-1]) begin
         rf_row_q <= rf_row_q + 7'h01;
      end
   end

   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         MA <= 7'h00;
      end else if (kind_q == DSRC_REFR) begin
         MA <= rf_row_q;
      end else if (taps[`DSRC_CAS_TAP-2] || cas_on) begin // Column held while CAS low
         MA <= addr[`DSRC_COL_HI:`DSRC_COL_LO]; // Column = low bits [R21]
      end else begin
         MA <= addr[`DSRC_ROW_HI:`DSRC_ROW_LO]; // Row = high bits [R21]
      end
   end

   // Busy flag; a short fixed cycle keeps the bus free of waits [R07]
   always_ff @(posedge MCLK) begin
      if (!RST_B) begin
         BUSY <= 1'b0;
      end else begin
         BUSY <= ras_en;
      end
   end
endmodule : dsrc_ctrl
`default_nettype wire

// File: test/dsrc_ctrl_sva.sv
// Port checker for the strobe and refresh controller.
// Assumes it is bound into dsrc_ctrl and sees only that module's ports.
`include "dsrc_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module dsrc_ctrl_sva (
   input wire logic MCLK,
   input wire logic RST_B,
   input wire logic WR_B,
   input wire logic INHIBIT,
   input wire logic BUS_GRANT,
   input wire dsrc_pkg::dsrc_rfmode_t RF_MODE,
   input wire logic [`DSRC_BANKS-1:0] SOFT_RAS_FORCE,
   input wire logic HOLD_REQ,
   input wire logic [`DSRC_BANKS-1:0] RAS_B,
   input wire logic CAS_B,
   input wire logic WE_B
);
   import dsrc_pkg::*;
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RST_B);
   logic [5:0] low_q; // Clocks since a row strobe fell
   // Saturating count, so a stuck strobe cannot wrap back into the window
   always_ff @(posedge MCLK) begin
      if (!RST_B || &RAS_B) low_q <= 6'h00;
      else if (low_q != 6'h3F) low_q <= low_q + 6'h01;
   end
   sequence s_ras_fall; $fell(&RAS_B); endsequence
   sequence s_ras_back; ##[38:40] (&RAS_B); endsequence
   property p_cas_delay; $fell(CAS_B) |-> low_q >= 6'h10 && low_q <= 6'h14; endproperty
   a_cas_delay: assert property (p_cas_delay) else $error("column strobe outside its window");
   property p_ras_span; s_ras_fall |-> s_ras_back; endproperty
   a_ras_span: assert property (p_ras_span) else $error("row strobe never released");
   property p_cas_in_ras; !CAS_B |-> !(&RAS_B); endproperty
   a_cas_in_ras: assert property (p_cas_in_ras) else $error("column strobe without row strobe");
   property p_one_bank; !CAS_B && SOFT_RAS_FORCE == 4'h0 |-> $onehot(~RAS_B); endproperty
   a_one_bank: assert property (p_one_bank) else $error("access strobes more than one bank");
   property p_refr_all; RAS_B == 4'h0 && SOFT_RAS_FORCE == 4'h0 |-> CAS_B && WE_B; endproperty
   a_refr_all: assert property (p_refr_all) else $error("refresh with column or write strobe");
   property p_wr_wait; $fell(WR_B) && &RAS_B |-> ##1 (&RAS_B) [*6]; endproperty
   a_wr_wait: assert property (p_wr_wait) else $error("write began before data settled");
   property p_inhibit; $fell(CAS_B) |-> !$past(INHIBIT, 10); endproperty
   a_inhibit: assert property (p_inhibit) else $error("inhibited cycle reached memory");
   property p_grant_refr; $rose(BUS_GRANT) && HOLD_REQ |-> ##[2:10] RAS_B == 4'h0; endproperty
   a_grant_refr: assert property (p_grant_refr) else $error("grant gave no refresh");
   property p_hold_mode; HOLD_REQ |-> RF_MODE == DSRC_RF_HOLD; endproperty
   a_hold_mode: assert property (p_hold_mode) else $error("hold asked outside hold mode");
   property p_we_in_ras; !WE_B |-> !(&RAS_B); endproperty
   a_we_in_ras: assert property (p_we_in_ras) else $error("write enable outside a row cycle");
endmodule : dsrc_ctrl_sva
bind dsrc_ctrl dsrc_ctrl_sva u_sva (.MCLK(MCLK), .RST_B(RST_B), .WR_B(WR_B), .INHIBIT(INHIBIT),
   .BUS_GRANT(BUS_GRANT), .RF_MODE(RF_MODE), .SOFT_RAS_FORCE(SOFT_RAS_FORCE), .HOLD_REQ(HOLD_REQ),
   .RAS_B(RAS_B), .CAS_B(CAS_B), .WE_B(WE_B));
`default_nettype wire

// File: test/dsrc_cpu_model.sv
// Processor bus model: address phase, status, write strobe, hold grant.
// Assumes the bench calls cycle() and the controller asks for the bus by hold_req.
`timescale 1ns/1ps
`default_nettype none
module dsrc_cpu_model (
   input wire logic clk,
   input wire logic hold_req,
   output logic [7:0] ad,
   output logic [7:0] a_hi,
   output logic ale,
   output logic s1,
   output logic s0,
   output logic wr_b,
   output logic grant
);
   bit busy = 1'b0; // Own bus cycle running
   bit slow = 1'b0; // Alternates prompt and slow grants
   int gap = 0; // Clocks still to wait before granting
   logic [13:0] tmr_q = 14'h0000; // Refresh timer count
   logic timer_output = 1'b0; // Timer tick, on the top priority interrupt
   localparam logic [15:0] TMR_LOAD = 16'hD5A4; // Top two bits set: reload
   // Refresh timer on the processor clock; reload keeps it recurring
   always @(posedge clk) begin
      #1;
      timer_output = (tmr_q == 14'h0001);
      if (tmr_q != 14'h0000) tmr_q = tmr_q - 14'h0001;
      else if (&TMR_LOAD[15:14]) tmr_q = TMR_LOAD[13:0];
   end
   // Idle bus at time zero
   initial begin
      {ad, a_hi} = 16'h0000;
      {ale, s1, s0} = 3'h0;
      wr_b = 1'b1;
      grant = 1'b0;
   end
   // Grant only between own cycles; a floated bus shows no stable value
   always @(posedge clk) begin
      #1;
      if (grant) ad = ~ad;
      if (!hold_req) begin
         grant = 1'b0;
      end else if (!busy && !grant && gap > 0) begin
         gap--;
      end else if (!busy && !grant) begin
         grant = 1'b1; // Refresh never waits behind another master
         slow = !slow;
         gap = slow ? 5 : 0;
      end
   end
   // One bus cycle; waits while a hold is asked or granted
   task automatic cycle(input bit wr, input bit fetch, input logic [15:0] a);
      do begin
         @(posedge clk);
         #1;
      end while (grant || hold_req);
      busy = 1'b1;
      {a_hi, ad} = a;
      s1 = !wr; // Status: read 10, write 01, fetch 11
      s0 = wr | fetch;
      ale = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      ale = 1'b0;
      @(posedge clk);
      #1;
      ad = ~a[7:0]; // Bus moves on to data
      wr_b = !wr;
      // Long enough for the timing chain to drain before the next address
      repeat (48) @(posedge clk);
      #1;
      wr_b = 1'b1;
      {s1, s0} = 2'h0;
      busy = 1'b0;
   endtask : cycle
endmodule : dsrc_cpu_model
`default_nettype wire

// File: test/tb_dsrc_ctrl.sv
// Self-checking bench for the strobe and refresh controller.
// Assumes the bus model drives the processor side and answers holds.
`timescale 1ns/1ps
`default_nettype none
module tb_dsrc_ctrl;
   import dsrc_pkg::*;
   logic MCLK, RST_B, INHIBIT, REFRESH_REQ, ALE, S1, S0, WR_B, BUS_GRANT, HOLD_REQ, CAS_B, WE_B, BUSY, cas_p;
   dsrc_rfmode_t RF_MODE; // Refresh scheme in use
   logic [3:0] SOFT_RAS_FORCE, RAS_B, ras_p; // Forced banks, strobes, last sample
   logic [7:0] AD, A_HI;
   logic [6:0] MA;
   logic [31:0] r;
   int seed, error_cnt, checked, rcnt, i, cur_col, cur_we, cur_ras;
   bit owed; // Reference refresh owed in fetch mode
   int q_ras[$], q_row[$], q_col[$], q_we[$]; // Expected memory cycles in order
   dsrc_ctrl dut (.MCLK(MCLK), .RST_B(RST_B), .AD(AD), .A_HI(A_HI), .ALE(ALE), .BUS_STATUS_BIT_ONE(S1),
      .BUS_STATUS_BIT_ZERO(S0), .WR_B(WR_B), .INHIBIT(INHIBIT), .REFRESH_REQ(REFRESH_REQ), .BUS_GRANT(BUS_GRANT),
      .RF_MODE(RF_MODE), .SOFT_RAS_FORCE(SOFT_RAS_FORCE), .HOLD_REQ(HOLD_REQ), .RAS_B(RAS_B), .CAS_B(CAS_B),
      .WE_B(WE_B), .MA(MA), .BUSY(BUSY));
   dsrc_cpu_model cpu (.clk(MCLK), .hold_req(HOLD_REQ), .ad(AD), .a_hi(A_HI), .ale(ALE), .s1(S1), .s0(S0),
      .wr_b(WR_B), .grant(BUS_GRANT));
   always #4 MCLK = ~MCLK;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      checked++;
      if (got !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic push(input int ras, input int row, input int col, input int we);
      q_ras.push_back(ras);
      q_row.push_back(row);
      q_col.push_back(col);
      q_we.push_back(we);
   endtask : push
   // Refresh: all banks, next row of the counter, no column strobe
   task automatic push_ref;
      push(0, rcnt % 128, 255, 1);
      rcnt++;
   endtask : push_ref
   task automatic pulse;
      REFRESH_REQ = 1'b1; // One request per interval, far inside the limit
      @(posedge MCLK);
      #1;
      REFRESH_REQ = 1'b0;
      owed = (RF_MODE == DSRC_RF_FETCH);
      // A hold refresh keeps the chain busy this long
      repeat (48) @(posedge MCLK);
      #1;
   endtask : pulse
   // One processor cycle plus its expected memory cycle
   task automatic bus(input bit wr, input bit fetch, input bit inh, input logic [15:0] a);
      INHIBIT = inh;
      if (fetch && owed && RF_MODE == DSRC_RF_FETCH) begin
         push_ref();
         owed = 1'b0;
      end else if (!inh) begin
         push(4'hF & ~((4'h1 << a[15:14]) | SOFT_RAS_FORCE), a[13:7], a[6:0], !wr);
      end
      cpu.cycle(wr, fetch, a);
   endtask : bus
   task automatic test_done;
      if (error_cnt == 0 && checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : test_done
   // Hold-mode refresh follows each grant
   always @(posedge BUS_GRANT) push_ref();
   // Compare strobes and address at each row and column strobe fall
   always @(negedge MCLK) begin
      if (RST_B && &ras_p && !(&RAS_B)) begin
         if (q_ras.size() == 0) chk("unexpected row cycle", 8'h00, 8'h01);
         else begin
            cur_ras = q_ras.pop_front();
            cur_col = q_col.pop_front();
            cur_we = q_we.pop_front();
            chk("row strobes", cur_ras, RAS_B);
            chk("busy", 8'h01, BUSY);
            chk("row address", q_row.pop_front(), {1'b0, MA});
         end
      end
      if (RST_B && cas_p && !CAS_B) begin
         chk("column address", cur_col, {1'b0, MA});
         chk("write enable", cur_we, WE_B);
         chk("column row strobes", cur_ras, RAS_B);
      end
      ras_p = RAS_B;
      cas_p = CAS_B;
   end
   initial begin
      repeat (20000) @(posedge MCLK);
      error_cnt++;
      test_done();
   end
   initial begin
      seed = 35097;
      {MCLK, RST_B, INHIBIT, REFRESH_REQ, owed} = 5'h00;
      RF_MODE = DSRC_RF_HOLD;
      SOFT_RAS_FORCE = 4'h0;
      ras_p = 4'hF;
      cas_p = 1'b1;
      rcnt = 0;
      repeat (16) @(posedge MCLK);
      #1;
      RST_B = 1'b1;
      chk("idle strobes", 8'h3F, {CAS_B, WE_B, RAS_B});
      chk("idle hold and address", 8'h00, {HOLD_REQ, MA});
      // Hold mode: random reads, fetches, writes, some inhibited, refreshes between
      for (i = 0; i < 16; i++) begin
         r = $random(seed);
         bus(r[0], r[1], r[3:2] == 2'h0, r[31:16]);
         if (r[4]) pulse();
      end
      pulse();
      pulse();
      repeat (60) @(posedge MCLK);
      #1;
      RF_MODE = DSRC_RF_FETCH;
      pulse();
      bus(1'b0, 1'b1, 1'b0, 16'h7FFF);
      bus(1'b0, 1'b1, 1'b0, 16'h8000);
      RF_MODE = DSRC_RF_SOFT;
      for (i = 0; i < 8; i++) begin
         r = $random(seed);
         SOFT_RAS_FORCE = r[7:4];
         pulse();
         bus(r[0], 1'b0, i == 7, r[31:16]);
      end
      // Timer tick: one dummy read per row, all banks forced
      @(posedge cpu.timer_output);
      SOFT_RAS_FORCE = 4'hF;
      for (i = 0; i < 128; i++) begin
         r = $random(seed);
         bus(1'b0, 1'b0, 1'b0, {r[15:14], 7'(i), r[6:0]});
      end
      repeat (60) @(posedge MCLK);
      chk("pending cycles", 8'h00, q_ras.size());
      test_done();
   end
endmodule : tb_dsrc_ctrl
`default_nettype wire
